// File: hw/lcs_flag_filter.sv
// Two-stage synchroniser and settle filter for one comparator flag
`timescale 1ns/100ps
module lcs_flag_filter
    import lcs_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Flag
    input wire logic raw,
    output logic filt
);
    logic sync_a;
    logic sync_b;
    logic [FILT_W-1:0] cnt;

    wire differs = (sync_b != filt);
    wire settled = (cnt == FILT_W'(FILT_CYC - 1));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
            cnt <= '0;
            filt <= 1'b0;
        end else begin
            sync_a <= raw;
            sync_b <= sync_a;
            // Glitches shorter than the settle time never reach the latches
            cnt <= (differs && !settled) ? cnt + 1'b1 : '0;
            if (differs && settled) begin
                filt <= sync_b;
            end
        end
    end
endmodule

// File: hw/lcs_pkg.sv
// Shared constants and types for the LED channel supervisor
package lcs_pkg;
    localparam int CLK_HZ = 125_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int NUM_CH = 6;
    localparam int MAX_FAULTS = 4;
    localparam int DIM_LEVELS = 16;
    localparam int LVL_W = 4;
    localparam int CNT_CH_W = 3;
    // Comparator flag settle time, least time so round up
    localparam int FILT_NS = 1000;
    localparam int FILT_CYC = (FILT_NS * CYC_PER_US + 999) / 1000;
    localparam int FILT_W = 8;
    // Blanking after each dimming on-edge before faults are sampled
    localparam int BLANK_CYC = 2 * FILT_CYC;
    localparam int AGE_W = 9;
    // Time the reference node is held at its preset level
    localparam int PRESET_US = 20;
    localparam int PRESET_CYC = PRESET_US * CYC_PER_US;
    localparam int PRE_W = 12;
    // Overvoltage retry rate
    localparam int OVP_CYCLE_HZ = 2;
    localparam int OVP_CYCLE_CYC = CLK_HZ / OVP_CYCLE_HZ;
    localparam int CYC_W = 26;
    // Internal dimming frequency per range, sixteen steps per period
    localparam int DIM_LF_HZ = 1000;
    localparam int DIM_HF_HZ = 10000;
    localparam int DIM_LF_STEP_CYC = CLK_HZ / (DIM_LF_HZ * DIM_LEVELS);
    localparam int DIM_HF_STEP_CYC = CLK_HZ / (DIM_HF_HZ * DIM_LEVELS);
    localparam int STEP_W = 16;
    // Duty measurement counter width, covers a 100 Hz input period
    localparam int MEAS_W = 24;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_PRESET = 4'h2,
        ST_RUN = 4'h4,
        ST_OVP_WAIT = 4'h8
    } lcs_state_t;
endpackage

// File: hw/lcs_supervisor.sv
// Six-channel LED fault, dimming and overvoltage supervisor
`timescale 1ns/100ps
module lcs_supervisor
    import lcs_pkg::*;
#(
    parameter int OVP_CYCLE_CYC_P = OVP_CYCLE_CYC,
    parameter int DIM_LF_STEP_P = DIM_LF_STEP_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Control pins
    input wire logic enable_pin,
    input wire logic dim_ratio_input,
    input wire logic dim_freq_select_pin,
    input wire logic mode_pin,
    // Channel comparator flags
    input wire logic [NUM_CH-1:0] io_open_flag,
    input wire logic [NUM_CH-1:0] io_short_flag,
    input wire logic [NUM_CH-1:0] io_below_reg,
    input wire logic [NUM_CH-1:0] io_above_reg,
    // Boost comparator flags
    input wire logic ovp_trip_flag,
    input wire logic ovp_release_flag,
    input wire logic ref_ceiling_flag,
    // Reference node controls
    output logic ref_preset_close,
    output logic ref_charge,
    output logic ref_discharge,
    // Boost and dimming
    output logic boost_run,
    output logic internal_dim_pulse,
    output logic dim_range_hf,
    output logic [LVL_W-1:0] dim_level,
    // Channel drive and status
    output logic [NUM_CH-1:0] channel_drive,
    output logic [NUM_CH-1:0] channel_fault,
    output logic ovp_cycling
);
    localparam int NFLAG = 4 * NUM_CH + 4;

    function automatic logic [CNT_CH_W-1:0] lcs_popcount(input logic [NUM_CH-1:0] v);
        logic [CNT_CH_W-1:0] c;
        c = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            c = c + CNT_CH_W'(v[i]);
        end
        return c;
    endfunction

    function automatic logic [LVL_W-1:0] lcs_quantise(input logic [MEAS_W-1:0] hi,
                                                      input logic [MEAS_W-1:0] per);
        logic [MEAS_W+LVL_W-1:0] scaled;
        logic [LVL_W-1:0] q;
        scaled = {hi, 4'h0};
        q = 4'h0;
        for (int n = 1; n < DIM_LEVELS; n++) begin
            if (scaled >= {4'h0, per} * (MEAS_W + LVL_W)'(n)) begin
                q = LVL_W'(n);
            end
        end
        return q;
    endfunction

    // Flag synchronisers and filters
    wire [NFLAG-1:0] raw_flags = {enable_pin, ref_ceiling_flag, ovp_release_flag, ovp_trip_flag,
                                  io_above_reg, io_below_reg, io_short_flag, io_open_flag};
    logic [NFLAG-1:0] flags_f;

    for (genvar g = 0; g < NFLAG; g++) begin : gen_filt
        lcs_flag_filter u_filt (
            .clk_sys(clk_sys),
            .srst(srst),
            .raw(raw_flags[g]),
            .filt(flags_f[g])
        );
    end

    wire [NUM_CH-1:0] open_f = flags_f[NUM_CH-1:0];
    wire [NUM_CH-1:0] short_f = flags_f[2*NUM_CH-1:NUM_CH];
    wire [NUM_CH-1:0] below_f = flags_f[3*NUM_CH-1:2*NUM_CH];
    wire [NUM_CH-1:0] above_f = flags_f[4*NUM_CH-1:3*NUM_CH];
    wire trip_f = flags_f[4*NUM_CH];
    wire release_f = flags_f[4*NUM_CH+1];
    wire ceiling_f = flags_f[4*NUM_CH+2];
    wire en_f = flags_f[4*NUM_CH+3];

    // Dimming pins pass only a synchroniser: a filter would eat short duty
    logic [2:0] pin_a;
    logic [2:0] pin_b;
    logic drc_d;
    wire drc_s = pin_b[0];
    wire ext_s = pin_b[1];
    wire mode_s = pin_b[2];
    wire drc_rise = drc_s && !drc_d;

    // Duty measurement of the ratio input
    logic [MEAS_W-1:0] meas_total;
    logic [MEAS_W-1:0] meas_high;
    logic [MEAS_W-1:0] lat_total;
    logic [MEAS_W-1:0] lat_high;
    logic lat_new;
    logic [LVL_W-1:0] level;
    wire total_max = &meas_total;
    wire high_max = &meas_high;
    // Rise cycle is itself high, so both counts restart at one
    wire [MEAS_W-1:0] next_total = drc_rise ? MEAS_W'(1) : (total_max ? meas_total : meas_total + 1'b1);
    wire [MEAS_W-1:0] next_high = drc_rise ? MEAS_W'(1) :
                                  ((drc_s && !high_max) ? meas_high + 1'b1 : meas_high);
    // A vanished input keeps the last level, the same as the analog part does
    wire [LVL_W-1:0] next_level = (lat_new && lat_total != '0) ? lcs_quantise(lat_high, lat_total) : level;

    // Internal dimming generator
    logic [STEP_W-1:0] step_cnt;
    logic [LVL_W-1:0] step_idx;
    wire [STEP_W-1:0] step_len = mode_s ? STEP_W'(DIM_HF_STEP_CYC) : STEP_W'(DIM_LF_STEP_P);
    wire step_wrap = (step_cnt >= step_len - 1'b1);
    wire gen_pulse = (step_idx < level);
    wire dim_src = ext_s ? mode_s : gen_pulse;
    wire dim_zero = !ext_s && (level == '0);

    // Supervisor state
    lcs_state_t st;
    lcs_state_t next_st;
    logic [PRE_W-1:0] pre_cnt;
    logic [CYC_W-1:0] cyc_cnt;
    wire cyc_done = (cyc_cnt == '0);
    wire pre_done = (pre_cnt == '0);
    wire in_run = (st == ST_RUN);
    wire boost_state = (st == ST_PRESET) || in_run;
    // Recovery waits for both the 1.7V release and the retry period
    wire restart = en_f && release_f && cyc_done;
    wire enter_preset = (st == ST_OFF && en_f) || (st == ST_OVP_WAIT && restart);

    always_comb begin
        next_st = st;
        unique case (st)
            ST_OFF: if (en_f) next_st = ST_PRESET;
            ST_PRESET: begin
                if (!en_f) next_st = ST_OFF;
                else if (trip_f) next_st = ST_OVP_WAIT;
                else if (pre_done) next_st = ST_RUN;
            end
            ST_RUN: begin
                if (!en_f) next_st = ST_OFF;
                else if (trip_f) next_st = ST_OVP_WAIT;
            end
            ST_OVP_WAIT: begin
                if (!en_f) next_st = ST_OFF;
                else if (restart) next_st = ST_PRESET;
            end
            default: next_st = ST_OFF;
        endcase
    end

    // Fault acceptance, blanked after each dim on-edge
    logic [AGE_W-1:0] on_age;
    wire age_full = (on_age == AGE_W'(BLANK_CYC));
    wire sample_ok = in_run && dim_src && age_full;
    // Only the two window comparators count; mid-range collector is fine
    wire [NUM_CH-1:0] fault_hit = (open_f | short_f) & {NUM_CH{sample_ok}};
    logic [NUM_CH-1:0] next_fault;

    always_comb begin
        logic [CNT_CH_W-1:0] cnt;
        cnt = lcs_popcount(channel_fault);
        next_fault = channel_fault;
        for (int i = 0; i < NUM_CH; i++) begin
            // Lowest channel wins when several fail in one cycle
            if (!next_fault[i] && fault_hit[i] && cnt < CNT_CH_W'(MAX_FAULTS)) begin
                next_fault[i] = 1'b1;
                cnt = cnt + 1'b1;
            end
        end
    end

    // Reference loop direction, held through dim off-time
    logic dir_up;
    logic dir_valid;
    wire ref_active = in_run && dim_src;
    wire charge_req = |(below_f & ~channel_fault);
    wire discharge_req = &(above_f | channel_fault);
    wire next_dir_valid = (!in_run || dim_zero) ? 1'b0 :
                          (ref_active ? (charge_req || discharge_req) : dir_valid);
    wire next_dir_up = ref_active ? charge_req : dir_up;
    wire next_charge = in_run && dir_valid && dir_up && !ceiling_f && !dim_zero;
    wire next_discharge = in_run && dir_valid && !dir_up && !dim_zero;
    wire next_boost = boost_state && dim_src && !trip_f;
    wire [NUM_CH-1:0] next_drive = ~next_fault & {NUM_CH{boost_state && dim_src}};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_a <= '0;
            pin_b <= '0;
            drc_d <= 1'b0;
        end else begin
            pin_a <= {mode_pin, dim_freq_select_pin, dim_ratio_input};
            pin_b <= pin_a;
            drc_d <= drc_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meas_total <= '0;
            meas_high <= '0;
            lat_total <= '0;
            lat_high <= '0;
            lat_new <= 1'b0;
            level <= '0;
        end else begin
            meas_total <= next_total;
            meas_high <= next_high;
            lat_new <= drc_rise;
            if (drc_rise) begin
                lat_total <= meas_total;
                lat_high <= meas_high;
            end
            level <= next_level;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            step_cnt <= '0;
            step_idx <= '0;
            on_age <= '0;
        end else begin
            step_cnt <= step_wrap ? '0 : step_cnt + 1'b1;
            step_idx <= step_wrap ? step_idx + 1'b1 : step_idx;
            on_age <= !dim_src ? '0 : (age_full ? on_age : on_age + 1'b1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st <= ST_OFF;
            pre_cnt <= '0;
            cyc_cnt <= '0;
            dir_up <= 1'b0;
            dir_valid <= 1'b0;
        end else begin
            st <= next_st;
            pre_cnt <= enter_preset ? PRE_W'(PRESET_CYC - 1) : (pre_done ? pre_cnt : pre_cnt - 1'b1);
            cyc_cnt <= enter_preset ? CYC_W'(OVP_CYCLE_CYC_P - 1) : (cyc_done ? cyc_cnt : cyc_cnt - 1'b1);
            dir_up <= next_dir_up;
            dir_valid <= next_dir_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ref_preset_close <= 1'b0;
            ref_charge <= 1'b0;
            ref_discharge <= 1'b0;
            boost_run <= 1'b0;
            internal_dim_pulse <= 1'b0;
            dim_range_hf <= 1'b0;
            dim_level <= '0;
            channel_drive <= '0;
            channel_fault <= '0;
            ovp_cycling <= 1'b0;
        end else begin
            ref_preset_close <= (st == ST_PRESET);
            ref_charge <= next_charge;
            ref_discharge <= next_discharge;
            boost_run <= next_boost;
            internal_dim_pulse <= dim_src;
            dim_range_hf <= mode_s && !ext_s;
            dim_level <= level;
            channel_drive <= next_drive;
            channel_fault <= next_fault;
            ovp_cycling <= (next_st == ST_OVP_WAIT);
        end
    end

    preset_exclusive_a: assert property (@(posedge clk_sys) disable iff (srst)
        ref_preset_close |-> !ref_charge && !ref_discharge)
        else $error("reference moved while preset switch closed");
    ref_direction_a: assert property (@(posedge clk_sys) disable iff (srst)
        !(ref_charge && ref_discharge))
        else $error("reference charged and discharged together");
    ext_dim_follow_a: assert property (@(posedge clk_sys) disable iff (srst)
        ext_s |=> internal_dim_pulse == $past(mode_s))
        else $error("external dim pulse not followed");
    fault_sticky_a: assert property (@(posedge clk_sys) disable iff (srst)
        (channel_fault & $past(channel_fault)) == $past(channel_fault))
        else $error("latched channel fault cleared");
    faulted_undriven_a: assert property (@(posedge clk_sys) disable iff (srst)
        (channel_drive & channel_fault) == '0)
        else $error("faulted channel still driven");
    fault_limit_a: assert property (@(posedge clk_sys) disable iff (srst)
        lcs_popcount(channel_fault) <= CNT_CH_W'(MAX_FAULTS))
        else $error("more than four channels latched");
    trip_stops_a: assert property (@(posedge clk_sys) disable iff (srst)
        trip_f && en_f && boost_state |=> !boost_run && ovp_cycling)
        else $error("boost kept switching after trip");
    restart_preset_a: assert property (@(posedge clk_sys) disable iff (srst)
        st == ST_OVP_WAIT && restart |-> ##2 ref_preset_close && !ovp_cycling)
        else $error("restart without reference preset");
    cycle_reload_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(st == ST_PRESET) |-> cyc_cnt == CYC_W'(OVP_CYCLE_CYC_P - 1))
        else $error("retry counter not reloaded");
    boost_gated_a: assert property (@(posedge clk_sys) disable iff (srst)
        boost_run |-> internal_dim_pulse)
        else $error("boost switching with dim pulse low");
endmodule

// File: hw/lcs_supervisor_end.sv
// No logic here; the supervisor and its flag filter sit in their own files

// File: tb/lcs_led_model.sv
// LED string and dimming source model facing the supervisor
`timescale 1ns/100ps
module lcs_led_model
    import lcs_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // String conditions set by the bench
    input wire logic [NUM_CH-1:0] open_mask,
    input wire logic [NUM_CH-1:0] short_mask,
    input wire logic [NUM_CH-1:0] low_mask,
    input wire logic [NUM_CH-1:0] high_mask,
    // Dimming source setup
    input wire logic pwm_on,
    input wire logic [15:0] pwm_per,
    input wire logic [15:0] pwm_high,
    // Comparator flags and dimming input
    output logic [NUM_CH-1:0] io_open_flag,
    output logic [NUM_CH-1:0] io_short_flag,
    output logic [NUM_CH-1:0] io_below_reg,
    output logic [NUM_CH-1:0] io_above_reg,
    output logic dim_ratio_input
);
    logic [15:0] pcnt = 16'h0000;
    // Open string pulls the collector low whether driven or not
    assign io_open_flag = open_mask;
    assign io_short_flag = short_mask;
    assign io_below_reg = low_mask | open_mask;
    // Shorted LEDs sit above regulation and also raise the short flag
    assign io_above_reg = high_mask | short_mask;
    // Source idles low when off, no stale level left behind
    assign dim_ratio_input = pwm_on && (pcnt < pwm_high);
    always @(posedge clk_sys) begin
        pcnt <= (pcnt >= pwm_per - 16'h0001) ? 16'h0000 : pcnt + 16'h0001;
    end
endmodule

// File: tb/tb_lcs_supervisor.sv
// Self-checking bench for the LED channel supervisor
`timescale 1ns/100ps
module tb_lcs_supervisor
    import lcs_pkg::*;
;
    logic clk_sys, srst, enable_pin, dim_freq_select_pin, mode_pin, dim_ratio_input;
    logic ovp_trip_flag, ovp_release_flag, ref_ceiling_flag, pwm_on;
    logic [NUM_CH-1:0] open_mask, short_mask, low_mask, high_mask;
    logic [NUM_CH-1:0] io_open_flag, io_short_flag, io_below_reg, io_above_reg;
    logic ref_preset_close, ref_charge, ref_discharge, boost_run, internal_dim_pulse;
    logic dim_range_hf, ovp_cycling;
    logic [LVL_W-1:0] dim_level;
    logic [NUM_CH-1:0] channel_drive, channel_fault;
    int err_total = 0;
    int checks = 0;
    int cyc_cnt = 0;
    int n, x, n0, n1, hi, bad;

    // Short retry and step counts keep the run brief
    lcs_supervisor #(.OVP_CYCLE_CYC_P(2000), .DIM_LF_STEP_P(50)) dut (
        .clk_sys(clk_sys), .srst(srst), .enable_pin(enable_pin), .dim_ratio_input(dim_ratio_input),
        .dim_freq_select_pin(dim_freq_select_pin), .mode_pin(mode_pin), .io_open_flag(io_open_flag),
        .io_short_flag(io_short_flag), .io_below_reg(io_below_reg), .io_above_reg(io_above_reg),
        .ovp_trip_flag(ovp_trip_flag), .ovp_release_flag(ovp_release_flag),
        .ref_ceiling_flag(ref_ceiling_flag), .ref_preset_close(ref_preset_close), .ref_charge(ref_charge),
        .ref_discharge(ref_discharge), .boost_run(boost_run), .internal_dim_pulse(internal_dim_pulse),
        .dim_range_hf(dim_range_hf), .dim_level(dim_level), .channel_drive(channel_drive),
        .channel_fault(channel_fault), .ovp_cycling(ovp_cycling)
    );

    lcs_led_model strings (
        .clk_sys(clk_sys), .open_mask(open_mask), .short_mask(short_mask), .low_mask(low_mask),
        .high_mask(high_mask), .pwm_on(pwm_on), .pwm_per(16'h0190), .pwm_high(16'h00C8),
        .io_open_flag(io_open_flag), .io_short_flag(io_short_flag), .io_below_reg(io_below_reg),
        .io_above_reg(io_above_reg), .dim_ratio_input(dim_ratio_input)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        if (err_total == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // Bounded wait, sampling just after each edge once outputs settle
    task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
        k = 0;
        while (s !== v && k < lim) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
    endtask

    // Run length is near 20k cycles, so the ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 60000) begin
            err_total++;
            test_done();
        end
    end

    initial begin
        srst = 1'b1;
        enable_pin = 1'b0;
        dim_freq_select_pin = 1'b0;
        mode_pin = 1'b0;
        ovp_trip_flag = 1'b0;
        ovp_release_flag = 1'b0;
        ref_ceiling_flag = 1'b0;
        pwm_on = 1'b0;
        {open_mask, short_mask, low_mask, high_mask} = 24'h000000;
        cyc(10);
        srst <= 1'b0;
        cyc(1);
        #1;
        chk("outputs_idle", 32'h0, {ref_preset_close, ref_charge, boost_run, channel_drive, channel_fault});
        // Supply first, then dimming input, then enable
        cyc(1);
        pwm_on <= 1'b1;
        cyc(1600);
        enable_pin <= 1'b1;
        wait_lvl(ref_preset_close, 1'b1, 400, n);
        chk("ref_preset_close", 1, ref_preset_close);
        wait_lvl(ref_preset_close, 1'b0, 3000, n);
        chk("preset_len", 1, n >= 2490 && n <= 2510);
        cyc(1);
        mode_pin <= 1'b1;
        cyc(5);
        #1;
        chk("dim_range_hf", 1, dim_range_hf);
        cyc(1);
        mode_pin <= 1'b0;
        cyc(5);
        #1;
        chk("dim_range_lf", 0, dim_range_hf);
        cyc(2000);
        hi = 0;
        bad = 0;
        repeat (800) begin
            @(posedge clk_sys);
            #1;
            hi += int'(internal_dim_pulse === 1'b1);
            bad += int'(boost_run !== internal_dim_pulse);
        end
        chk("dim_level", 8, dim_level);
        chk("dim_high_cycles", 400, hi);
        chk("boost_gating", 1, bad <= 4);
        cyc(1);
        low_mask <= 6'h01;
        wait_lvl(ref_charge, 1'b1, 2000, n);
        chk("ref_charge", 1, ref_charge);
        cyc(1);
        ref_ceiling_flag <= 1'b1;
        cyc(300);
        hi = 0;
        repeat (800) begin
            @(posedge clk_sys);
            #1;
            hi += int'(ref_charge !== 1'b0);
        end
        chk("charge_at_ceiling", 0, hi);
        cyc(1);
        ref_ceiling_flag <= 1'b0;
        low_mask <= 6'h00;
        high_mask <= 6'h3F;
        wait_lvl(ref_discharge, 1'b1, 2000, n);
        chk("ref_discharge", 1, ref_discharge);
        chk("mid_collector_fault", 0, channel_fault);
        cyc(1);
        high_mask <= 6'h00;
        open_mask <= 6'h20;
        cyc(60);
        open_mask <= 6'h00;
        cyc(1000);
        #1;
        chk("glitch_fault", 0, channel_fault);
        cyc(1);
        open_mask <= 6'h02;
        short_mask <= 6'h08;
        cyc(1700);
        #1;
        chk("open_short_fault", 32'h0A, channel_fault);
        cyc(1);
        open_mask <= 6'h00;
        short_mask <= 6'h00;
        cyc(1700);
        #1;
        chk("fault_held", 32'h0A, channel_fault);
        wait_lvl(internal_dim_pulse, 1'b0, 900, n);
        wait_lvl(internal_dim_pulse, 1'b1, 900, n);
        cyc(20);
        #1;
        chk("healthy_drive", 32'h35, channel_drive);
        cyc(1);
        open_mask <= 6'h05;
        cyc(1700);
        open_mask <= 6'h25;
        cyc(1700);
        #1;
        chk("fault_cap", 32'h0F, channel_fault);
        wait_lvl(internal_dim_pulse, 1'b0, 900, n);
        wait_lvl(internal_dim_pulse, 1'b1, 900, n);
        cyc(20);
        #1;
        chk("last_two_on", 32'h30, channel_drive);
        chk("no_ovp_from_opens", 0, ovp_cycling);
        cyc(1);
        ovp_trip_flag <= 1'b1;
        wait_lvl(ovp_cycling, 1'b1, 400, n);
        chk("ovp_cycling", 1, ovp_cycling);
        chk("boost_stopped", 0, boost_run);
        cyc(1);
        ovp_trip_flag <= 1'b0;
        ovp_release_flag <= 1'b1;
        wait_lvl(ref_preset_close, 1'b1, 3000, n);
        chk("restart_preset", 1, ref_preset_close);
        cyc(1);
        ovp_release_flag <= 1'b0;
        ovp_trip_flag <= 1'b1;
        wait_lvl(ovp_cycling, 1'b1, 400, n0);
        cyc(1);
        ovp_trip_flag <= 1'b0;
        ovp_release_flag <= 1'b1;
        wait_lvl(ref_preset_close, 1'b0, 10, x);
        wait_lvl(ref_preset_close, 1'b1, 3000, n1);
        chk("ovp_period", 1, n0 + x + n1 + 2 >= 2000 && n0 + x + n1 + 2 <= 2300);
        cyc(1);
        open_mask <= 6'h00;
        wait_lvl(boost_run, 1'b1, 3500, n);
        chk("reconnect_boost", 1, boost_run);
        chk("reconnect_no_ovp", 0, ovp_cycling);
        cyc(1);
        enable_pin <= 1'b0;
        cyc(300);
        #1;
        chk("fault_over_disable", 32'h0F, channel_fault);
        cyc(1);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        cyc(2);
        #1;
        chk("fault_power_cycle", 0, channel_fault);
        cyc(1);
        dim_freq_select_pin <= 1'b1;
        mode_pin <= 1'b1;
        enable_pin <= 1'b1;
        cyc(6);
        #1;
        chk("ext_pulse_high", 1, internal_dim_pulse);
        chk("ext_range", 0, dim_range_hf);
        cyc(1);
        mode_pin <= 1'b0;
        cyc(5);
        #1;
        chk("ext_pulse_low", 0, internal_dim_pulse);
        test_done();
    end
endmodule
